// file: hdl/ldg_lowside_guard.sv
// What this block does
// - Digital, extended low-voltage or power-on reset clears the control-enable value.
// - Overvoltage event also clears control-enable when the correction input is set.
// - Overvoltage flag shuts drivers off until software acknowledges it or a power-on reset clears it.
// - Drivers stay off unless main and sleep-regulator digital logic both report ok.
module ldg_lowside_guard #(
  parameter int BANDGAP_WINDOW_CYCLES = ldg_pkg::BANDGAP_WINDOW_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ldg_pkg::ldg_resets_t supply_resets,
  input wire ldg_pkg::ldg_supply_t supply_status,
  input wire logic regulator_overvoltage_detect,
  input wire logic ov_clear_correction,
  input wire logic ctrl_write,
  input wire logic [7:0] ctrl_write_data,
  input wire logic ov_flag_ack,
  input wire logic conv_done,
  input wire logic [3:0] conv_channel,
  input wire logic bandgap_overuse_clear,
  output logic lowside_driver_enable,
  output logic [7:0] lowside_control_enable,
  output logic regulator_overvoltage_flag,
  output logic shutdown_pulse,
  output ldg_pkg::ldg_cause_t off_cause,
  output logic bandgap_overuse_pulse,
  output logic bandgap_overuse_seen
);

  // ****************************************
  // State
  // ****************************************
  ldg_pkg::ldg_state_t st;
  ldg_pkg::ldg_state_t next_st;
  logic any_reset;
  logic supplies_ok;
  logic ov_rise;
  logic armed;
  logic run;

  // ****************************************
  // Gating logic
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.shutdown_pulse = 1'b0;
    any_reset = supply_resets.digital_low_voltage_reset
      | supply_resets.extended_low_voltage_reset
      | supply_resets.power_on_reset;
    supplies_ok = supply_status.main_digital_ok
      & supply_status.sleep_regulator_domain_ok;
    ov_rise = regulator_overvoltage_detect && !st.ov_detect_prev;
    next_st.ov_detect_prev = regulator_overvoltage_detect;

    // Software write of the enable value; hardware clears below take priority
    if (ctrl_write)
    begin
      next_st.lowside_control_enable = ctrl_write_data;
    end
    if (ov_rise && ov_clear_correction)
    begin
      next_st.lowside_control_enable = ldg_pkg::CTRL_ENABLE_RESET;
    end
    if (any_reset)
    begin
      next_st.lowside_control_enable = ldg_pkg::CTRL_ENABLE_RESET;
    end

    // Flag: acknowledge clears, a live detect sets, and the set wins
    if (ov_flag_ack)
    begin
      next_st.regulator_overvoltage_flag = 1'b0;
    end
    if (supply_resets.power_on_reset)
    begin
      next_st.regulator_overvoltage_flag = 1'b0;
    end
    if (regulator_overvoltage_detect)
    begin
      next_st.regulator_overvoltage_flag = 1'b1;
    end

    // Gate uses the stored enable and flag with the live detect, supplies and resets; the registered output never glitches on a write or a trip
    armed = (st.lowside_control_enable == ldg_pkg::CTRL_ENABLE_ARM);
    run = armed
      && !st.regulator_overvoltage_flag
      && !regulator_overvoltage_detect
      && supplies_ok
      && !any_reset;
    next_st.lowside_driver_enable = run;

    // Cause bits describe why the driver is off now, zero while it runs
    next_st.off_cause.by_reset = any_reset;
    next_st.off_cause.by_overvoltage = regulator_overvoltage_detect;
    next_st.off_cause.by_supply = !supplies_ok;
    next_st.off_cause.by_flag = st.regulator_overvoltage_flag;
    if (st.lowside_driver_enable && !run)
    begin
      next_st.shutdown_pulse = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign lowside_driver_enable = st.lowside_driver_enable;
  assign lowside_control_enable = st.lowside_control_enable;
  assign regulator_overvoltage_flag = st.regulator_overvoltage_flag;
  assign shutdown_pulse = st.shutdown_pulse;
  assign off_cause = st.off_cause;

  // ****************************************
  // Bandgap read monitor
  // ****************************************
  // Only reports; it cannot stop a false trip, the conversions are software's
  ldg_bandgap_monitor #(
    .WINDOW_CYCLES(BANDGAP_WINDOW_CYCLES)
  ) u_bandgap_monitor (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .conv_done(conv_done),
    .conv_channel(conv_channel),
    .overuse_clear(bandgap_overuse_clear),
    .overuse_pulse(bandgap_overuse_pulse),
    .overuse_seen(bandgap_overuse_seen)
  );

endmodule

// file: hdl/ldg_pkg.sv
package ldg_pkg;

  // ****************************************
  // Arming and field layout
  // ****************************************
  localparam logic [7:0] CTRL_ENABLE_ARM = 8'h05;
  localparam logic [7:0] CTRL_ENABLE_RESET = 8'h00;
  localparam int CTRL_ENABLE_WIDTH = 8;

  // ****************************************
  // Bandgap channel limits
  // ****************************************
  localparam logic [3:0] BANDGAP_CHANNEL = 4'hE;
  localparam logic [2:0] BANDGAP_MAX_READS = 3'h4;
  localparam int BANDGAP_WINDOW_NS = 400000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int BANDGAP_WINDOW_CYCLES = BANDGAP_WINDOW_NS / CLK_PERIOD_NS;
  localparam int WINDOW_CNT_WIDTH = 17;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic digital_low_voltage_reset;
    logic extended_low_voltage_reset;
    logic power_on_reset;
  } ldg_resets_t;

  typedef struct packed {
    logic main_digital_ok;
    logic sleep_regulator_domain_ok;
  } ldg_supply_t;

  typedef struct packed {
    logic by_reset;
    logic by_overvoltage;
    logic by_supply;
    logic by_flag;
  } ldg_cause_t;

  typedef struct packed {
    logic [7:0] lowside_control_enable;
    logic regulator_overvoltage_flag;
    logic ov_detect_prev;
    logic lowside_driver_enable;
    ldg_cause_t off_cause;
    logic shutdown_pulse;
  } ldg_state_t;

  typedef struct packed {
    logic [WINDOW_CNT_WIDTH-1:0] window_cnt;
    logic [2:0] run_cnt;
    logic overuse_pulse;
    logic overuse_seen;
  } ldg_mon_t;

endpackage

// file: hdl/ldg_bandgap_monitor.sv
module ldg_bandgap_monitor #(
  parameter int WINDOW_CYCLES = ldg_pkg::BANDGAP_WINDOW_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic conv_done,
  input wire logic [3:0] conv_channel,
  input wire logic overuse_clear,
  output logic overuse_pulse,
  output logic overuse_seen
);

  // ****************************************
  // State
  // ****************************************
  ldg_pkg::ldg_mon_t st;
  ldg_pkg::ldg_mon_t next_st;
  logic window_end;
  logic is_bandgap;

  // Last count of a window, cut to the counter width
  localparam int WINDOW_LAST = WINDOW_CYCLES - 1;
  localparam logic [ldg_pkg::WINDOW_CNT_WIDTH-1:0] WINDOW_CNT_LAST =
    WINDOW_LAST[ldg_pkg::WINDOW_CNT_WIDTH-1:0];

  // Window is free running; a burst may straddle two windows and go unseen
  always_comb
  begin
    next_st = st;
    next_st.overuse_pulse = 1'b0;
    window_end = (st.window_cnt == WINDOW_CNT_LAST);
    is_bandgap = conv_done && (conv_channel == ldg_pkg::BANDGAP_CHANNEL);
    if (window_end)
    begin
      next_st.window_cnt = '0;
      next_st.run_cnt = 3'h0;
    end
    else
    begin
      next_st.window_cnt = st.window_cnt + 1'b1;
    end
    if (conv_done && !is_bandgap)
    begin
      next_st.run_cnt = 3'h0;
    end
    else if (is_bandgap)
    begin
      if (st.run_cnt == ldg_pkg::BANDGAP_MAX_READS)
      begin
        next_st.overuse_pulse = 1'b1;
      end
      else
      begin
        next_st.run_cnt = (window_end ? 3'h0 : st.run_cnt) + 3'h1;
      end
    end
    if (overuse_clear)
    begin
      next_st.overuse_seen = 1'b0;
    end
    // Set wins over clear
    if (next_st.overuse_pulse)
    begin
      next_st.overuse_seen = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign overuse_pulse = st.overuse_pulse;
  assign overuse_seen = st.overuse_seen;

endmodule

// file: sim/ldg_lowside_guard_props.sv
module ldg_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ldg_pkg::ldg_resets_t supply_resets,
  input wire ldg_pkg::ldg_supply_t supply_status,
  input wire logic regulator_overvoltage_detect,
  input wire logic ov_clear_correction,
  input wire logic ov_flag_ack,
  input wire logic lowside_driver_enable,
  input wire logic [7:0] lowside_control_enable,
  input wire logic regulator_overvoltage_flag,
  input wire logic shutdown_pulse,
  input wire logic bandgap_overuse_pulse,
  input wire logic bandgap_overuse_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence armed;
    lowside_control_enable == 8'h05 && !regulator_overvoltage_flag
    && !regulator_overvoltage_detect && &supply_status && !(|supply_resets);
  endsequence
  sequence en_fall;
    lowside_driver_enable ##1 !lowside_driver_enable;
  endsequence
  chk_reset_clear: assert property (|supply_resets |=> lowside_control_enable == 8'h00)
    else $error("control enable kept over reset");
  chk_ov_clear: assert property (ov_clear_correction && $rose(regulator_overvoltage_detect)
    |=> lowside_control_enable == 8'h00) else $error("control enable kept over trip");
  chk_flag_set: assert property (regulator_overvoltage_detect
    |=> regulator_overvoltage_flag && !lowside_driver_enable) else $error("trip missed");
  chk_ack_clear: assert property (ov_flag_ack && !regulator_overvoltage_detect
    |=> !regulator_overvoltage_flag) else $error("flag kept after ack");
  chk_supply_gate: assert property (!(&supply_status) |=> !lowside_driver_enable)
    else $error("driver on without supplies");
  chk_arm_path: assert property (armed |=> lowside_driver_enable)
    else $error("driver not enabled");
  chk_arm_only: assert property (lowside_driver_enable |-> $past(lowside_control_enable) == 8'h05)
    else $error("driver on unarmed");
  chk_fall_pulse: assert property (en_fall |-> shutdown_pulse)
    else $error("no shutdown pulse");
  chk_overuse_seen: assert property (bandgap_overuse_pulse |-> bandgap_overuse_seen)
    else $error("overuse not held");
endmodule

// file: sim/ldg_sw_model.sv
module ldg_sw_model (
  input wire logic clk_sys,
  output logic ctrl_write = 1'b0,
  output logic [7:0] ctrl_write_data = 8'h00,
  output logic ov_flag_ack = 1'b0,
  output logic conv_done = 1'b0,
  output logic [3:0] conv_channel = 4'h0,
  output logic bandgap_overuse_clear = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****
  // Software strobes, data inverted once released
  // ****
  task automatic write_ctrl(input logic [7:0] d);
    @(posedge clk_sys);
    #1 {ctrl_write, ctrl_write_data} = {1'b1, d};
    @(posedge clk_sys);
    #1 {ctrl_write, ctrl_write_data} = {1'b0, ~d};
  endtask
  task automatic ack();
    @(posedge clk_sys);
    #1 ov_flag_ack = 1'b1;
    @(posedge clk_sys);
    #1 ov_flag_ack = 1'b0;
  endtask
  task automatic conv(input logic [3:0] c);
    @(posedge clk_sys);
    #1 {conv_done, conv_channel} = {1'b1, c};
    @(posedge clk_sys);
    #1 {conv_done, conv_channel} = {1'b0, ~c};
  endtask
  task automatic clear_overuse();
    @(posedge clk_sys);
    #1 bandgap_overuse_clear = 1'b1;
    @(posedge clk_sys);
    #1 bandgap_overuse_clear = 1'b0;
  endtask
endmodule

// file: sim/ldg_lowside_guard_tb.sv
module ldg_lowside_guard_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  ldg_pkg::ldg_resets_t rs = '0;
  ldg_pkg::ldg_supply_t ok = 2'h3;
  logic det = 1'b0;
  logic corr = 1'b0;
  logic wr, ack, cd, oc, en, flag, sd, bs, bp;
  ldg_pkg::ldg_cause_t cause;
  int pulses = 0;
  logic [7:0] wd, ctl, v;
  logic [3:0] ch;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  ldg_sw_model i_ldg_sw_model (.clk_sys, .ctrl_write(wr), .ctrl_write_data(wd),
    .ov_flag_ack(ack), .conv_done(cd), .conv_channel(ch), .bandgap_overuse_clear(oc));
  // ****
  // Short window keeps the overuse test inside one window
  // ****
  ldg_lowside_guard #(.BANDGAP_WINDOW_CYCLES(200)) i_ldg_lowside_guard (.clk_sys, .rst_n,
    .supply_resets(rs), .supply_status(ok), .regulator_overvoltage_detect(det),
    .ov_clear_correction(corr), .ctrl_write(wr), .ctrl_write_data(wd), .ov_flag_ack(ack),
    .conv_done(cd), .conv_channel(ch), .bandgap_overuse_clear(oc), .lowside_driver_enable(en),
    .lowside_control_enable(ctl), .regulator_overvoltage_flag(flag), .shutdown_pulse(sd),
    .off_cause(cause), .bandgap_overuse_pulse(bp), .bandgap_overuse_seen(bs));
  initial
    forever #2 clk_sys = ~clk_sys;
  // Pulses last one cycle, so count them mid-cycle
  always @(negedge clk_sys)
    if (bp)
      pulses++;
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] exp_en(input logic [7:0] c);
    return {7'h00, c == ldg_pkg::CTRL_ENABLE_ARM};
  endfunction
  task automatic arm();
    i_ldg_sw_model.write_ctrl(8'h05);
    step(1);
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    void'($urandom(33));
    step(16);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 8'h05 : 8'($urandom);
      i_ldg_sw_model.write_ctrl(v);
      check(ctl, v);
      step(1);
      check({7'h00, en}, exp_en(v));
    end
    $display("writes done");
    arm();
    det = 1'b1;
    step(1);
    check({5'h00, flag, en, sd}, 8'h05);
    check({4'h0, cause}, 8'h04);
    check(ctl, 8'h05);
    det = 1'b0;
    i_ldg_sw_model.ack();
    step(1);
    check({7'h00, en}, 8'h01);
    {corr, det} = 2'h3;
    step(1);
    check(ctl, 8'h00);
    det = 1'b0;
    i_ldg_sw_model.ack();
    step(1);
    check({7'h00, en}, 8'h00);
    arm();
    check({7'h00, en}, 8'h01);
    $display("trip done");
    for (int i = 0; i < 3; i++)
    begin
      rs = 3'(1 << i);
      step(1);
      check({ctl[6:0], en}, 8'h00);
      check({4'h0, cause}, 8'h08);
      rs = '0;
      arm();
    end
    $display("resets done");
    for (int i = 0; i < 2; i++)
    begin
      ok = ~2'(1 << i);
      step(1);
      check({7'h00, en}, 8'h00);
      check({4'h0, cause}, 8'h02);
      ok = 2'h3;
      step(1);
      check({7'h00, en}, 8'h01);
    end
    $display("supplies done");
    repeat (10) i_ldg_sw_model.conv(4'hE);
    step(1);
    check({7'h00, bs}, 8'h01);
    check(8'(pulses), 8'h06);
    i_ldg_sw_model.clear_overuse();
    // A foreign channel first, since the run of four stays until broken
    for (int i = 0; i < 10; i++)
      i_ldg_sw_model.conv((i % 5 == 0) ? 4'(1 + $urandom % 13) : 4'hE);
    step(1);
    check({7'h00, bs}, 8'h00);
    check(8'(pulses), 8'h06);
    $display("bandgap done");
    rst_n = 1'b0;
    step(1);
    check(ctl, 8'h00);
    check({cause, flag, en, sd, bs}, 8'h00);
    rst_n = 1'b1;
    step(2);
    check({6'h00, en, flag}, 8'h00);
    arm();
    check({7'h00, en}, 8'h01);
    $display("reset release done");
    tally_and_finish();
  end
endmodule
bind ldg_lowside_guard ldg_props i_ldg_props (.clk_sys, .rst_n, .supply_resets,
  .supply_status, .regulator_overvoltage_detect, .ov_clear_correction, .ov_flag_ack,
  .lowside_driver_enable, .lowside_control_enable, .regulator_overvoltage_flag,
  .shutdown_pulse, .bandgap_overuse_pulse, .bandgap_overuse_seen);
